/* rtl/speed_mon_pkg.sv */
/*
  Constants, register map and configuration layout for the axis speed
  limit monitor. Assumes a 100 MHz logic clock and an AXI4-Lite host.
*/
package speed_mon_pkg;

  // Register byte offsets; limit n sits at ADDR_LIM0 + 4*n.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIM0 = 8'h04;
  localparam logic [7:0] ADDR_LOW = 8'h14;
  localparam logic [7:0] ADDR_HIGH = 8'h18;
  localparam logic [7:0] ADDR_RES = 8'h1C;
  localparam logic [7:0] ADDR_GEAR = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h24;
  localparam logic [7:0] ADDR_FREQ0 = 8'h28;
  localparam logic [7:0] ADDR_FREQ1 = 8'h2C;

  // Reset values: gear ratio 1 and hysteresis 5 percent, unit resolutions.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LIM_RST = 32'h00FF_FFFF;
  localparam logic [31:0] RES_RST = 32'h0001_0001;
  localparam logic [31:0] GEAR_RST = 32'h0000_0501;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Measured frequency width, hysteresis divisor and fault thresholds.
  localparam int FREQ_W = 24;
  localparam logic [31:0] HYST_DIV = 32'h0000_0064;
  localparam logic [23:0] MISS_MIN = 24'h00_0004;
  localparam int MISMATCH_SHIFT = 3;

  // Gate time: one count per second reads directly in Hz.
  localparam int CLK_PERIOD_NS = 10;
  localparam int GATE_TIME_MS = 1000;
  localparam int GATE_CYCLES = GATE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DEV_ENC, DEV_PROX, DEV_ENC_PROX, DEV_PROX_PROX, DEV_ENC_ENC
  } meas_dev_t;

  typedef enum logic [1:0] {DIR_BI, DIR_CW, DIR_CCW} dir_mode_t;

  // Control register layout, bit 0 is dir_en.
  typedef struct packed {
    logic [16:0] rsvd;
    logic four_wire;
    logic prox_nc;
    logic prox_npn;
    logic sensor_linear;
    logic axis_linear;
    meas_dev_t dev;
    logic range_mode;
    logic [1:0] thr_code;
    dir_mode_t dir_mode;
    logic err_en;
    logic dir_en;
  } cfg_t;

endpackage : speed_mon_pkg

/* rtl/sync_2ff.sv */
/*
  Two flip-flop synchroniser for a bundle of asynchronous pins.
  Assumes each bit is independent; no word coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : sync_2ff
`default_nettype wire

/* rtl/pulse_channel.sv */
/*
  One measuring channel: a quadrature encoder or a proximity switch.
  Assumes its inputs are already synchronised to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic a,
  input wire logic b,
  input wire logic is_enc,
  input wire logic invert,
  input wire logic four_wire,
  output logic pulse,
  output logic dir_ccw,
  output logic fault
);

  logic a_q;
  logic b_q;
  logic lvl;
  logic lvl_q;
  logic both_moved;
  logic wire_bad;

  // NPN and normally closed each flip the sense of the switch.
  assign lvl = a ^ invert;
  assign lvl_q = a_q ^ invert;
  // A quadrature pair never changes both phases in one sample.
  assign both_moved = (a != a_q) && (b != b_q);
  // The complementary wire must disagree; two samples mask switching skew.
  assign wire_bad = (a == b) && (a_q == b_q);

  // Previous samples for edge detection.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a;
      b_q <= b;
    end
  end

  // Count one pulse per rising edge and record the turning sense.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse <= 1'b0;
      dir_ccw <= 1'b0;
    end else begin
      pulse <= is_enc ? (a && !a_q) : (lvl && !lvl_q);
      if (is_enc && a && !a_q) begin
        dir_ccw <= b;
      end
    end
  end

  // Phase error on encoders, broken wire on four-wire switches.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault <= 1'b0;
    end else begin
      fault <= (is_enc && both_moved) || (!is_enc && four_wire && wire_bad);
    end
  end

endmodule : pulse_channel
`default_nettype wire

/* rtl/axis_speed_limit_monitor.sv */
/*
  Axis speed limit monitor: measures pulse frequency from one or two
  sensors over a gate time and drives overspeed, in-range, direction and
  error outputs. Assumes an AXI4-Lite master on ref_clk and sensor and
  limit-select pins that are asynchronous to ref_clk.
*/
// Overview of operation
// - Direction output, when enabled, is high for counterclockwise, low for clockwise.
// - Bidirectional setting applies limits for either turning sense.
// - Clockwise-only or counterclockwise-only evaluates limits only in that sense.
// - One to four overspeed limits may be configured.
// - With several limits, limit-select pins choose the active one.
// - Two limits: select zero low picks first, high picks second.
// - Four limits: select one and zero form the binary index.
// - Overspeed output low above the selected limit, high below it.
// - Speed changes within the hysteresis percentage do not switch outputs.
// - Two sensors are compared through the configured gear ratio.
// - Encoder, switch, encoder plus switch, two switches or two encoders.
// - Range mode: in-range output low above the high limit.
// - Range mode: in-range output low below the low limit.
// - Range mode: in-range output high between low and high limits.
// - Error output, when enabled, reports any detected fault.
// - Rotary axis, rotary sensor: frequency is rpm over 60 times resolution.
// - Linear axis, rotary sensor: m/min times 1000 over 60 pitch, times resolution.
// - Linear axis, linear sensor: mm/s times 1000 over micrometres per pulse.
// - Separate resolution for the first and the second measuring device.
// - Pitch takes effect only for a linear axis with rotary sensor.
// - Switch inputs: PNP or NPN, open or closed, three or four wire.
// - Error set on missing sensor, frequency mismatch, phase or wire error.
`timescale 1ns/1ps
`default_nettype none
module axis_speed_limit_monitor #(
  parameter int GATE_CYCLES = speed_mon_pkg::GATE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic sens0_a,
  input wire logic sens0_b,
  input wire logic sens1_a,
  input wire logic sens1_b,
  input wire logic limit_select_0,
  input wire logic limit_select_1,
  output logic over_ok,
  output logic in_range,
  output logic dir_out,
  output logic error_out
);

  localparam int FW = speed_mon_pkg::FREQ_W;

  logic rst_q1;
  logic rst_n;
  logic [5:0] pins;
  logic s0a, s0b, s1a, s1b, sel0, sel1;
  logic [31:0] ctrl, low_r, high_r, res_r, gear_r;
  logic [31:0] lim [4];
  speed_mon_pkg::cfg_t cfg;
  logic aw_got, w_got, do_write;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] rd_word;
  logic rd_ok;
  logic ch0_enc, ch1_enc, two_sens, invert;
  logic p0, p1, d0, d1, f0, f1;
  logic [31:0] gate_cnt;
  logic gate_done, upd;
  logic [FW-1:0] cnt0, cnt1, freq0, freq1;
  logic gate_fault, fault_q, dir_ccw;
  logic dir_match;
  logic [FW-1:0] eval;
  logic [1:0] sel_idx;
  logic [FW-1:0] lim_sel, lim_lo, high_lo;
  logic [FW:0] low_hi;
  logic high_bad, low_bad, next_high_bad, next_low_bad;
  logic [47:0] lhs, rhs, diff;
  logic miss, mismatch;

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  // Reset asserts at once and releases two edges later.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  sync_2ff #(.W(6)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({limit_select_1, limit_select_0, sens1_b, sens1_a, sens0_b, sens0_a}),
    .q(pins)
  );
  assign {sel1, sel0, s1b, s1a, s0b, s0a} = pins;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Address and data are taken in either order; no new write until answered.
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign do_write = aw_got && w_got;
  assign s_axi_arready = !s_axi_rvalid;

  // Write channel holding registers and response.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= speed_mon_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= speed_mon_pkg::ADDR_FREQ1) ?
                       speed_mon_pkg::RESP_OKAY : speed_mon_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; status words ignore writes.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= speed_mon_pkg::CTRL_RST;
      low_r <= 32'h0000_0000;
      high_r <= speed_mon_pkg::LIM_RST;
      res_r <= speed_mon_pkg::RES_RST;
      gear_r <= speed_mon_pkg::GEAR_RST;
      for (int i = 0; i < 4; i++) begin
        lim[i] <= speed_mon_pkg::LIM_RST;
      end
    end else if (do_write) begin
      case (aw_addr)
        speed_mon_pkg::ADDR_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
        speed_mon_pkg::ADDR_LOW: low_r <= merge(low_r, w_data, w_strb);
        speed_mon_pkg::ADDR_HIGH: high_r <= merge(high_r, w_data, w_strb);
        speed_mon_pkg::ADDR_RES: res_r <= merge(res_r, w_data, w_strb);
        speed_mon_pkg::ADDR_GEAR: gear_r <= merge(gear_r, w_data, w_strb);
        default: begin
          if (aw_addr >= speed_mon_pkg::ADDR_LIM0 && aw_addr < speed_mon_pkg::ADDR_LOW &&
              aw_addr[1:0] == 2'h0) begin
            lim[2'(aw_addr[4:2] - 3'h1)] <= merge(lim[2'(aw_addr[4:2] - 3'h1)], w_data, w_strb);
          end
        end
      endcase
    end
  end

  assign cfg = speed_mon_pkg::cfg_t'(ctrl);

  // Read decode; pitch reads back only where it takes effect.
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      speed_mon_pkg::ADDR_CTRL: rd_word = ctrl;
      speed_mon_pkg::ADDR_LOW: rd_word = low_r;
      speed_mon_pkg::ADDR_HIGH: rd_word = high_r;
      speed_mon_pkg::ADDR_RES: rd_word = res_r;
      speed_mon_pkg::ADDR_GEAR: begin
        rd_word = gear_r;
        if (!(cfg.axis_linear && !cfg.sensor_linear)) begin
          rd_word[31:16] = 16'h0000;
        end
      end
      speed_mon_pkg::ADDR_STAT: rd_word = {24'h00_0000, mismatch, miss, fault_q, dir_ccw,
                                           error_out, dir_out, in_range, over_ok};
      speed_mon_pkg::ADDR_FREQ0: rd_word = {8'h00, freq0};
      speed_mon_pkg::ADDR_FREQ1: rd_word = {8'h00, freq1};
      default: begin
        if (s_axi_araddr >= speed_mon_pkg::ADDR_LIM0 && s_axi_araddr < speed_mon_pkg::ADDR_LOW &&
            s_axi_araddr[1:0] == 2'h0) begin
          rd_word = lim[2'(s_axi_araddr[4:2] - 3'h1)];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // Read answer one cycle after the address is taken.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= speed_mon_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? speed_mon_pkg::RESP_OKAY : speed_mon_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sensor channels and frequency measurement.

  // Measuring arrangement picks encoder or switch decoding per channel.
  assign ch0_enc = cfg.dev == speed_mon_pkg::DEV_ENC || cfg.dev == speed_mon_pkg::DEV_ENC_PROX ||
                   cfg.dev == speed_mon_pkg::DEV_ENC_ENC;
  assign ch1_enc = cfg.dev == speed_mon_pkg::DEV_ENC_ENC;
  assign two_sens = cfg.dev >= speed_mon_pkg::DEV_ENC_PROX;
  assign invert = cfg.prox_npn ^ cfg.prox_nc;

  pulse_channel u_ch0 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .a(s0a),
    .b(s0b),
    .is_enc(ch0_enc),
    .invert(invert),
    .four_wire(cfg.four_wire),
    .pulse(p0),
    .dir_ccw(d0),
    .fault(f0)
  );

  pulse_channel u_ch1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .a(s1a),
    .b(s1b),
    .is_enc(ch1_enc),
    .invert(invert),
    .four_wire(cfg.four_wire),
    .pulse(p1),
    .dir_ccw(d1),
    .fault(f1)
  );

  // One-second gate: counts read in Hz, the unit of the speed formulas.
  assign gate_done = gate_cnt == 32'(GATE_CYCLES - 1);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt <= 32'h0000_0000;
      upd <= 1'b0;
    end else begin
      gate_cnt <= gate_done ? 32'h0000_0000 : gate_cnt + 32'h0000_0001;
      upd <= gate_done;
    end
  end

  // Pulse counters latch at the gate end; a pulse in that cycle opens the next.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt0 <= '0;
      cnt1 <= '0;
      freq0 <= '0;
      freq1 <= '0;
      dir_ccw <= 1'b0;
    end else if (gate_done) begin
      freq0 <= cnt0;
      freq1 <= two_sens ? cnt1 : '0;
      dir_ccw <= ch0_enc ? d0 : (ch1_enc && d1);
      cnt0 <= FW'(p0);
      cnt1 <= FW'(p1);
    end else begin
      cnt0 <= (cnt0 == '1) ? cnt0 : cnt0 + FW'(p0);
      cnt1 <= (cnt1 == '1) ? cnt1 : cnt1 + FW'(p1);
    end
  end

  // Channel faults are sticky across a gate; a fault at the gate end is kept.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_fault <= 1'b0;
      fault_q <= 1'b0;
    end else if (gate_done) begin
      fault_q <= gate_fault || f0 || (two_sens && f1);
      gate_fault <= f0 || (two_sens && f1);
    end else begin
      gate_fault <= gate_fault || f0 || (two_sens && f1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit selection, direction filter and hysteresis bands.

  function automatic logic [FW-1:0] hyst_of(input logic [FW-1:0] v, input logic [7:0] h);
    logic [31:0] p;
    p = {8'h00, v} * {24'h00_0000, h};
    return FW'(p / speed_mon_pkg::HYST_DIV);
  endfunction : hyst_of

  // Thresholds number 1..4 comes from thr_code 0..3; three clamps to index 2.
  always_comb begin
    case (cfg.thr_code)
      2'h0: sel_idx = 2'h0;
      2'h1: sel_idx = {1'b0, sel0};
      2'h2: sel_idx = (sel1 && sel0) ? 2'h2 : {sel1, sel0};
      default: sel_idx = {sel1, sel0};
    endcase
  end

  assign lim_sel = lim[sel_idx][FW-1:0];

  // Directional settings zero the speed seen while turning the other way.
  assign dir_match = (cfg.dir_mode == speed_mon_pkg::DIR_BI) ||
                     (cfg.dir_mode == speed_mon_pkg::DIR_CW && !dir_ccw) ||
                     (cfg.dir_mode == speed_mon_pkg::DIR_CCW && dir_ccw);
  assign eval = dir_match ? freq0 : '0;

  // Return points lie the hysteresis percentage inside each limit.
  assign lim_lo = (lim_sel > hyst_of(lim_sel, gear_r[15:8])) ?
                  lim_sel - hyst_of(lim_sel, gear_r[15:8]) : '0;
  assign high_lo = (high_r[FW-1:0] > hyst_of(high_r[FW-1:0], gear_r[15:8])) ?
                   high_r[FW-1:0] - hyst_of(high_r[FW-1:0], gear_r[15:8]) : '0;
  assign low_hi = {1'b0, low_r[FW-1:0]} + {1'b0, hyst_of(low_r[FW-1:0], gear_r[15:8])};

  // Range flags set beyond a limit and clear only past the band.
  always_comb begin
    next_high_bad = high_bad;
    next_low_bad = low_bad;
    if (eval > high_r[FW-1:0]) begin
      next_high_bad = 1'b1;
    end else if (eval < high_lo) begin
      next_high_bad = 1'b0;
    end
    if (eval < low_r[FW-1:0]) begin
      next_low_bad = 1'b1;
    end else if ({1'b0, eval} > low_hi) begin
      next_low_bad = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sensor cross-check through gear ratio and resolutions.

  assign lhs = 48'(freq1) * 48'(res_r[15:0]);
  assign rhs = 48'(freq0) * 48'(res_r[31:16]) * 48'(gear_r[7:0]);
  assign diff = (lhs > rhs) ? lhs - rhs : rhs - lhs;
  assign mismatch = two_sens && diff > ((lhs > rhs ? lhs : rhs) >> speed_mon_pkg::MISMATCH_SHIFT);
  assign miss = two_sens && ((freq0 == '0 && freq1 >= speed_mon_pkg::MISS_MIN) ||
                             (freq1 == '0 && freq0 >= speed_mon_pkg::MISS_MIN));

  ////////////////////////////////////////////////////////////////////////
  // Outputs; direction refreshed every cycle, the others one cycle after each gate end.

  // Overspeed output; starts low until the first measurement is in.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      over_ok <= 1'b0;
    end else if (upd) begin
      if (eval > lim_sel) begin
        over_ok <= 1'b0;
      end else if (eval < lim_lo) begin
        over_ok <= 1'b1;
      end
    end
  end

  // Speed window output.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_bad <= 1'b0;
      low_bad <= 1'b1;
      in_range <= 1'b0;
    end else if (upd) begin
      high_bad <= next_high_bad;
      low_bad <= next_low_bad;
      in_range <= cfg.range_mode && !next_high_bad && !next_low_bad;
    end
  end

  // Direction follows the measured sense whenever enabled.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_out <= 1'b0;
    end else begin
      dir_out <= cfg.dir_en && dir_ccw;
    end
  end

  // Error output collects faults of the finished gate.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_out <= 1'b0;
    end else if (upd) begin
      error_out <= cfg.err_en && (fault_q || miss || mismatch);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence wr_pair;
    aw_got && w_got;
  endsequence
  sequence gate_end;
    gate_done ##1 upd;
  endsequence

  a_write_answer: assert property (wr_pair |=> s_axi_bvalid)
    else $error("write not answered");
  a_over_trip: assert property (upd && eval > lim_sel |=> !over_ok)
    else $error("overspeed not flagged");
  a_over_hold: assert property (upd && !over_ok && eval >= lim_lo |=> !over_ok)
    else $error("overspeed released inside band");
  a_over_clear: assert property (upd && eval < lim_lo |=> over_ok)
    else $error("overspeed not released");
  a_range_high: assert property (upd && eval > high_r[FW-1:0] |=> !in_range)
    else $error("in range above high limit");
  a_range_low: assert property (upd && eval < low_r[FW-1:0] |=> !in_range)
    else $error("in range below low limit");
  a_range_inside: assert property (upd && cfg.range_mode && eval < high_lo &&
                                   {1'b0, eval} > low_hi |=> in_range)
    else $error("in range not set");
  a_dir_block: assert property (upd && !dir_match |=> !$fell(over_ok))
    else $error("speed evaluated in wrong sense");
  a_sel_two: assert property (cfg.thr_code == 2'h1 |->
                              lim_sel == (sel0 ? lim[1][FW-1:0] : lim[0][FW-1:0]))
    else $error("two limit select wrong");
  a_sel_four: assert property (cfg.thr_code == 2'h3 |-> lim_sel == lim[{sel1, sel0}][FW-1:0])
    else $error("four limit select wrong");
  a_dir_gate: assert property (!cfg.dir_en |=> !dir_out)
    else $error("direction shown while disabled");
  a_err_mask: assert property (gate_end ##0 !cfg.err_en |=> !error_out)
    else $error("error shown while disabled");
  a_err_report: assert property (upd && cfg.err_en && (fault_q || miss || mismatch)
                                 |=> error_out)
    else $error("sensor fault not reported");

endmodule : axis_speed_limit_monitor
`default_nettype wire

/* sim/axis_sensor_model.sv */
/* Quadrature encoder on the moving axis.
   Assumes run and ccw change only after ref_clk edges. */
`timescale 1ns/1ps
`default_nettype none
module axis_sensor_model (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic ccw,
  output logic a,
  output logic b
);
  logic [1:0] ph = 2'h0;
  logic [2:0] cnt = 3'h0;
  // One phase step every five cycles; a stopped axis holds its pins.
  always_ff @(posedge ref_clk) begin
    if (run) begin
      cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      if (cnt == 3'h4) ph <= ccw ? ph + 2'h1 : ph - 2'h1;
    end
  end
  // Gray code, so b is high at a rise only when turning counterclockwise.
  assign a = ph[1];
  assign b = ph[1] ^ ph[0];
endmodule : axis_sensor_model
`default_nettype wire

/* sim/axis_speed_limit_monitor_tb_top.sv */
/* Bench: AXI4-Lite tasks, an expectation queue and one encoder.
   Assumes a 200-cycle gate, so about 10 pulses per gate. */
`timescale 1ns/1ps
`default_nettype none
module axis_speed_limit_monitor_tb_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r; logic p;} exp_t;
  exp_t q[$];
  logic ref_clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, sa, sb, at, wt, bt, rt, ok, rng, dir, err;
  logic run = 0, ccw = 0, sel0 = 0, sel1 = 0, s1 = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, lim;
  logic [1:0] bresp, rresp;
  integer seed = 32'hC3E450A1;
  int failures = 0, num_checks = 0;
  axis_sensor_model enc (.ref_clk(ref_clk), .run(run), .ccw(ccw), .a(sa), .b(sb));
  axis_speed_limit_monitor #(.GATE_CYCLES(200)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .sens0_a(sa), .sens0_b(sb), .sens1_a(sa & s1), .sens1_b(sb & s1), .limit_select_0(sel0),
    .limit_select_1(sel1), .over_ok(ok), .in_range(rng), .dir_out(dir), .error_out(err));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Handshakes are sampled mid-cycle so the decision never races the edge.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = 2'h0);
    q.push_back('{32'h0, 32'h0, r, 1'b0});
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bt = 1'b0;
    for (int n = 0; n < 50 && !bt; n++) begin
      @(negedge ref_clk);
      at = awready;
      wt = wready;
      bt = bvalid;
      @(posedge ref_clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // One idle edge keeps the next call from reassigning bready in this time step.
    @(posedge ref_clk);
    if (!bt) begin
      failures++;
      $display("Error at %0t: write not answered", $time);
      complete_run();
    end
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] d, m, input logic [1:0] r,
                    input logic p = 1'b0);
    q.push_back('{d, m, r, p});
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rt = 1'b0;
    for (int n = 0; n < 50 && !rt; n++) begin
      @(negedge ref_clk);
      at = arready;
      rt = rvalid;
      @(posedge ref_clk);
      if (at) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    // One idle edge keeps the next call from reassigning rready in this time step.
    @(posedge ref_clk);
    if (!rt) begin
      failures++;
      $display("Error at %0t: read not answered", $time);
      complete_run();
    end
  endtask : rd
  // Three gates let the outputs settle before the status word is read.
  task automatic st(input logic [3:0] e, m);
    repeat (600) @(posedge ref_clk);
    rd(8'h24, {28'h0, e}, {28'h0, m}, 2'h0, 1'b1);
  endtask : st
  ////////////////////////////////////////////////////////////////
  // Each bus answer is compared with the oldest expectation; status reads check the pins too.
  always @(negedge ref_clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      num_checks++;
      if (q.size() == 0 || (rdata & q[0].m) !== q[0].d || (bvalid ? bresp : rresp) !== q[0].r ||
          (q[0].p && ({err, dir, rng, ok} & q[0].m[3:0]) !== q[0].d[3:0])) begin
        failures++;
        $display("Error at %0t: read %h", $time, rdata);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Main sequence; the random limit stays well above the axis speed.
  initial begin
    lim = 32'h64 + ($random(seed) & 32'hFF);
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(8'h20, 32'h0007_0501);
    rd(8'h20, 32'h501, '1, 2'h0);
    rd(8'h30, 32'h0, '1, 2'h2);
    wr(8'h30, 32'h1, 2'h2);
    wr(8'h04, 32'h4);
    wr(8'h00, 32'h1);
    run <= 1'b1;
    ccw <= 1'b1;
    st(4'h4, 4'hF);
    wr(8'h04, lim);
    rd(8'h04, lim, '1, 2'h0);
    st(4'h5, 4'hF);
    ccw <= 1'b0;
    st(4'h1, 4'hF);
    wr(8'h10, 32'h4);
    wr(8'h00, 32'h31);
    sel0 <= 1'b1;
    sel1 <= 1'b1;
    st(4'h0, 4'h1);
    sel1 <= 1'b0;
    st(4'h1, 4'h1);
    sel1 <= 1'b1;
    wr(8'h00, 32'h39);
    st(4'h1, 4'h1);
    wr(8'h00, 32'h35);
    st(4'h0, 4'h1);
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h11);
    st(4'h0, 4'h1);
    wr(8'h00, 32'h21);
    st(4'h1, 4'h1);
    wr(8'h00, 32'h40);
    wr(8'h14, 32'h2);
    st(4'h2, 4'h2);
    wr(8'h18, 32'h4);
    st(4'h0, 4'h2);
    wr(8'h18, lim);
    wr(8'h14, 32'h32);
    st(4'h0, 4'h2);
    wr(8'h00, 32'h202);
    s1 <= 1'b1;
    st(4'h0, 4'h8);
    s1 <= 1'b0;
    st(4'h8, 4'h8);
    complete_run();
  end
endmodule : axis_speed_limit_monitor_tb_top
`default_nettype wire
